/* File: mtrac_lsu_model.sv */
// model of the strands' load/store pipelines that issue control register accesses
`timescale 1ns/1ns
module mtrac_lsu_model #(
    parameter int unsigned NUM_STRANDS = 4
) (
    input  wire logic                                    clk_sys,
    input  wire logic [NUM_STRANDS-1:0]                  rspValid,
    input  wire mtrac_pkg::mtrac_rsp_t [NUM_STRANDS-1:0] rspData,
    output logic      [NUM_STRANDS-1:0]                  reqValid,
    output mtrac_pkg::mtrac_req_t [NUM_STRANDS-1:0]      reqData
);
    logic                  [NUM_STRANDS-1:0] stageValid;
    mtrac_pkg::mtrac_req_t                   stageData [NUM_STRANDS];
    logic                  [NUM_STRANDS-1:0] seenValid;
    mtrac_pkg::mtrac_rsp_t                   seenData  [NUM_STRANDS];

    // idle pipelines at time zero
    initial
    begin
        reqValid   = '0;
        reqData    = '0;
        stageValid = '0;
    end

    // queues one access of a strand for the next fire
    task automatic stage(input int s, input mtrac_pkg::mtrac_op_t op, input mtrac_pkg::mtrac_mode_t mode,
                         input logic [7:0] address_space_id, input logic [15:0] va, input logic [63:0] wdata, input logic grant);
    begin
        stageData[s]  = '{op: op, mode: mode, address_space_id: address_space_id, va: va, wdata: wdata, grantCross: grant};
        stageValid[s] = 1'b1;
    end
    endtask

    // presents staged accesses for one cycle, idle strands show a changing pattern, then captures answers
    task automatic fire();
        mtrac_pkg::mtrac_req_t [NUM_STRANDS-1:0] nextData;
    begin
        for (int s = 0; s < NUM_STRANDS; s++)
            nextData[s] = stageValid[s] ? stageData[s] : mtrac_pkg::mtrac_req_t'(~reqData[s]);
        reqData    = nextData;
        reqValid   = stageValid;
        stageValid = '0;
        @(posedge clk_sys);
        #1;
        seenValid = rspValid;
        for (int s = 0; s < NUM_STRANDS; s++)
            seenData[s] = rspData[s];
    end
    endtask
endmodule

/* File: mtrac_pkg.sv */
// package: constants, types and request carriers for the multithread register access controller
package mtrac_pkg;

    localparam int unsigned DATA_W       = 64;
    localparam int unsigned ASI_W        = 8;
    localparam int unsigned VA_W         = 16;
    localparam int unsigned REG_IDX_W    = 3;
    localparam int unsigned NUM_REGS     = 8;

    // address space identifiers of the register classes (chosen)
    localparam logic [7:0]  ASI_STRAND   = 8'h63;
    localparam logic [7:0]  ASI_CORE     = 8'h64;
    localparam logic [7:0]  ASI_SUBSET   = 8'h65;
    localparam logic [7:0]  ASI_PROC     = 8'h66;
    localparam logic [7:0]  ASI_CORE_X   = 8'h67;

    // virtual address of register index zero; step of eight bytes
    localparam logic [15:0] VA_BASE      = 16'h0000;
    localparam int unsigned VA_SHIFT     = 3;

    // register index of the strand-running register within the processor class
    localparam logic [2:0]  IDX_RUNNING  = 3'h0;
    // register index of the read-only id register within the strand class
    localparam logic [2:0]  IDX_STRAND_ID = 3'h0;
    // read-only tick copy within the processor class
    localparam logic [2:0]  IDX_TICK     = 3'h7;

    localparam logic [63:0] RESET_VALUE  = 64'h0000_0000_0000_0000;
    localparam logic [63:0] RUNNING_MASK = 64'h0000_0000_0000_00ff;

    typedef enum logic [1:0] { MTRAC_USER, MTRAC_PRIV, MTRAC_HPRIV, MTRAC_RSVD } mtrac_mode_t;

    typedef enum logic [2:0]
    {
        MTRAC_OP_LOAD_EXT,
        MTRAC_OP_LOAD_DBL,
        MTRAC_OP_STORE_EXT,
        MTRAC_OP_STORE_DBL,
        MTRAC_OP_OTHER
    } mtrac_op_t;

    typedef enum logic [1:0] { MTRAC_EXC_NONE, MTRAC_EXC_PRIV_ACTION, MTRAC_EXC_DATA_ACCESS, MTRAC_EXC_BAD_ASI } mtrac_exc_t;

    typedef struct packed
    {
        mtrac_op_t          op;
        mtrac_mode_t        mode;
        logic [ASI_W-1:0]   address_space_id;
        logic [VA_W-1:0]    va;
        logic [DATA_W-1:0]  wdata;
        logic               grantCross;
    } mtrac_req_t;

    typedef struct packed
    {
        logic [DATA_W-1:0]  rdata;
        mtrac_exc_t         exc;
        logic               dropped;
        logic               overwritten;
    } mtrac_rsp_t;

endpackage

/* File: multithread_reg_access_ctrl.sv */
// module: multithread control register bank with privilege checks and strand arbitration
`timescale 1ns/1ns
module multithread_reg_access_ctrl #(
    parameter int unsigned NUM_STRANDS      = 4,
    parameter int unsigned STRANDS_PER_CORE = 2,
    parameter int unsigned STRANDS_PER_SUB  = 2
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic [NUM_STRANDS-1:0]                reqValid,
    input  wire mtrac_pkg::mtrac_req_t [NUM_STRANDS-1:0] reqData,
    input  wire logic [mtrac_pkg::DATA_W-1:0]          tickValue,
    output logic      [NUM_STRANDS-1:0]                rspValid,
    output mtrac_pkg::mtrac_rsp_t [NUM_STRANDS-1:0]    rspData
);
    localparam int unsigned NUM_CORES = NUM_STRANDS / STRANDS_PER_CORE;
    localparam int unsigned NUM_SUBS  = NUM_STRANDS / STRANDS_PER_SUB;
    localparam int unsigned NR        = mtrac_pkg::NUM_REGS;

    // =====================================================================
    // storage for each sharing class
    // =====================================================================
    logic [63:0] strandRegs_reg [NUM_STRANDS*NR];
    logic [63:0] subRegs_reg    [NUM_SUBS*NR];
    logic [63:0] coreRegs_reg   [NUM_CORES*NR];
    logic [63:0] procRegs_reg   [NR];             // single copy

    // per-strand decode results
    logic [NUM_STRANDS-1:0] isStore;
    logic [NUM_STRANDS-1:0] accOk;
    logic [NUM_STRANDS-1:0] wrProc;
    logic [NUM_STRANDS-1:0] wrCore;
    logic [NUM_STRANDS-1:0] wrSub;
    logic [NUM_STRANDS-1:0] wrStrand;
    logic [2:0]             idx       [NUM_STRANDS];
    logic [31:0]            tgtCore   [NUM_STRANDS];
    logic [63:0]            rdVal     [NUM_STRANDS];
    mtrac_pkg::mtrac_exc_t  exc       [NUM_STRANDS];

    // =====================================================================
    // request decode per strand
    // =====================================================================
    genvar s;
    generate
        for (s = 0; s < NUM_STRANDS; s++)
        begin : g_dec
            mtrac_pkg::mtrac_req_t rq;
            logic isLoad;
            logic isExtSt;
            logic hpriv;
            logic asiStrand;
            logic asiCore;
            logic asiSub;
            logic asiProc;
            logic asiCross;
            logic vaOk;
            logic readOnly;
            logic [15:0] vaOff;
            logic [31:0] ownCore;
            logic [31:0] xCore;

            assign rq       = reqData[s];
            assign hpriv    = (rq.mode == mtrac_pkg::MTRAC_HPRIV);
            assign isLoad   = (rq.op == mtrac_pkg::MTRAC_OP_LOAD_EXT) ||
                              (rq.op == mtrac_pkg::MTRAC_OP_LOAD_DBL);
            assign isStore[s] = (rq.op == mtrac_pkg::MTRAC_OP_STORE_EXT) ||
                                (rq.op == mtrac_pkg::MTRAC_OP_STORE_DBL);
            assign isExtSt  = (rq.op == mtrac_pkg::MTRAC_OP_STORE_EXT);
            // register selection by asi plus virtual address
            assign vaOff    = rq.va - mtrac_pkg::VA_BASE;
            assign idx[s]   = vaOff[mtrac_pkg::VA_SHIFT +: 3];
            assign vaOk     = (vaOff[2:0] == 3'h0) && (vaOff[15:6] == 10'h000);
            assign asiStrand = (rq.address_space_id == mtrac_pkg::ASI_STRAND);
            assign asiCore  = (rq.address_space_id == mtrac_pkg::ASI_CORE);
            assign asiSub   = (rq.address_space_id == mtrac_pkg::ASI_SUBSET);
            assign asiProc  = (rq.address_space_id == mtrac_pkg::ASI_PROC);
            // cross-core: core number in va bits 15:6, needs hyperprivilege or grant
            assign asiCross = (rq.address_space_id == mtrac_pkg::ASI_CORE_X);
            assign ownCore  = s / STRANDS_PER_CORE;
            assign xCore    = 32'(rq.va[15:6]);
            assign tgtCore[s] = asiCross ? xCore : ownCore;
            assign readOnly = (asiStrand && idx[s] == mtrac_pkg::IDX_STRAND_ID) ||
                              (asiProc && idx[s] == mtrac_pkg::IDX_TICK);
            // exception priority: privilege, then opcode, then asi and address, then read-only store
            always_comb
            begin
                exc[s] = mtrac_pkg::MTRAC_EXC_NONE;
                if (!hpriv && !(asiCross && rq.grantCross))
                    exc[s] = mtrac_pkg::MTRAC_EXC_PRIV_ACTION;
                else if (!isLoad && !isStore[s])
                    exc[s] = mtrac_pkg::MTRAC_EXC_DATA_ACCESS;
                else if (!(asiStrand || asiCore || asiSub || asiProc) &&
                         !(asiCross && xCore < NUM_CORES && rq.va[5:0] == 6'h00 ||
                           asiCross && xCore < NUM_CORES))
                    exc[s] = mtrac_pkg::MTRAC_EXC_BAD_ASI;
                else if (!asiCross && !vaOk)
                    exc[s] = mtrac_pkg::MTRAC_EXC_BAD_ASI;
                else if (isStore[s] && readOnly)
                    exc[s] = isExtSt ? mtrac_pkg::MTRAC_EXC_BAD_ASI
                                     : mtrac_pkg::MTRAC_EXC_DATA_ACCESS;
            end
            assign accOk[s]    = reqValid[s] && (exc[s] == mtrac_pkg::MTRAC_EXC_NONE);
            assign wrStrand[s] = accOk[s] && isStore[s] && asiStrand;
            assign wrSub[s]    = accOk[s] && isStore[s] && asiSub;
            assign wrCore[s]   = accOk[s] && isStore[s] && (asiCore || asiCross);
            assign wrProc[s]   = accOk[s] && isStore[s] && asiProc;
            // read mux; tick is one shared copy invisible as such
            always_comb
            begin
                rdVal[s] = 64'h0;
                if (asiStrand)
                    rdVal[s] = (idx[s] == mtrac_pkg::IDX_STRAND_ID) ? 64'(s) : strandRegs_reg[s*NR + idx[s]];
                else if (asiSub)
                    rdVal[s] = subRegs_reg[(s/STRANDS_PER_SUB)*NR + idx[s]];
                else if (asiCore || asiCross)
                    rdVal[s] = coreRegs_reg[(tgtCore[s] % NUM_CORES)*NR + idx[s]];
                else if (asiProc)
                    rdVal[s] = (idx[s] == mtrac_pkg::IDX_TICK) ? tickValue : procRegs_reg[idx[s]];
            end
        end
    endgenerate

    // =====================================================================
    // arbitration: lowest-numbered strand wins each shared target
    // =====================================================================
    logic [NUM_STRANDS-1:0] lost;
    logic [NUM_STRANDS-1:0] runDrop;
    always_comb
    begin
        lost    = '0;
        runDrop = '0;
        for (int a = 0; a < NUM_STRANDS; a++)
            for (int b = 0; b < a; b++)
            begin
                if (wrProc[a] && wrProc[b] && idx[a] == idx[b])
                begin
                    // strand-running: colliding writes of higher-numbered strands are dropped
                    if (idx[a] == mtrac_pkg::IDX_RUNNING)
                        runDrop[a] = 1'b1;
                    else
                        lost[a] = 1'b1;
                end
                if (wrCore[a] && wrCore[b] && idx[a] == idx[b] && tgtCore[a] == tgtCore[b])
                    lost[a] = 1'b1;
                if (wrSub[a] && wrSub[b] && idx[a] == idx[b] &&
                    a / STRANDS_PER_SUB == b / STRANDS_PER_SUB)
                    lost[a] = 1'b1;
            end
    end

    // =====================================================================
    // register update; whole 64-bit word at once, one write per cycle per strand
    // =====================================================================
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_STRANDS*NR; i++) strandRegs_reg[i] <= mtrac_pkg::RESET_VALUE;
            for (int i = 0; i < NUM_SUBS*NR; i++)    subRegs_reg[i]    <= mtrac_pkg::RESET_VALUE;
            for (int i = 0; i < NUM_CORES*NR; i++)   coreRegs_reg[i]   <= mtrac_pkg::RESET_VALUE;
            for (int i = 0; i < NR; i++)             procRegs_reg[i]   <= mtrac_pkg::RESET_VALUE;
        end
        else
        begin
            for (int k = 0; k < NUM_STRANDS; k++)
            begin
                if (wrStrand[k])
                    strandRegs_reg[k*NR + idx[k]] <= reqData[k].wdata;
                if (wrSub[k] && !lost[k])
                    subRegs_reg[(k/STRANDS_PER_SUB)*NR + idx[k]] <= reqData[k].wdata;
                if (wrCore[k] && !lost[k])
                    coreRegs_reg[(tgtCore[k] % NUM_CORES)*NR + idx[k]] <= reqData[k].wdata;
                if (wrProc[k] && !lost[k] && !runDrop[k])
                    procRegs_reg[idx[k]] <= (idx[k] == mtrac_pkg::IDX_RUNNING)
                                            ? (reqData[k].wdata & mtrac_pkg::RUNNING_MASK)
                                            : reqData[k].wdata;
            end
        end
    end

    // =====================================================================
    // responses: one cycle after the request, in issue order per strand
    // =====================================================================
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspValid <= '0;
            rspData  <= '0;
        end
        else
        begin
            rspValid <= reqValid;
            for (int k = 0; k < NUM_STRANDS; k++)
            begin
                rspData[k].exc         <= exc[k];
                rspData[k].rdata       <= (accOk[k] && !isStore[k]) ? rdVal[k] : 64'h0;
                rspData[k].dropped     <= runDrop[k];
                rspData[k].overwritten <= lost[k];
            end
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    a_priv_check: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid[0] && reqData[0].mode != mtrac_pkg::MTRAC_HPRIV && !reqData[0].grantCross
        |=> rspValid[0] && rspData[0].exc == mtrac_pkg::MTRAC_EXC_PRIV_ACTION)
        else $error("unprivileged access not trapped");
    a_op_check: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid[0] && reqData[0].mode == mtrac_pkg::MTRAC_HPRIV && reqData[0].op == mtrac_pkg::MTRAC_OP_OTHER
        |=> rspData[0].exc == mtrac_pkg::MTRAC_EXC_DATA_ACCESS)
        else $error("bad opcode not trapped");
    a_ro_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid[0] && reqData[0].mode == mtrac_pkg::MTRAC_HPRIV && reqData[0].op == mtrac_pkg::MTRAC_OP_STORE_EXT
        && reqData[0].address_space_id == mtrac_pkg::ASI_STRAND && reqData[0].va == mtrac_pkg::VA_BASE
        |=> rspData[0].exc == mtrac_pkg::MTRAC_EXC_BAD_ASI)
        else $error("read-only store not trapped");
    a_proc_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrProc[0] && idx[0] == 3'h1 |=> procRegs_reg[1] == $past(reqData[0].wdata))
        else $error("processor register not updated");
    a_lowest_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrProc[0] && wrProc[1] && idx[0] == idx[1] && idx[0] != mtrac_pkg::IDX_RUNNING
        |=> rspData[1].overwritten && !rspData[0].overwritten)
        else $error("arbitration winner wrong");
    a_run_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrProc[0] && wrProc[1] && idx[0] == mtrac_pkg::IDX_RUNNING && idx[1] == mtrac_pkg::IDX_RUNNING
        |=> rspData[1].dropped)
        else $error("colliding running write not dropped");
    a_rsp_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid[0] |=> rspValid[0])
        else $error("response not one cycle later");
    a_strand_rd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrStrand[1] ##1 (reqValid[1] && accOk[1] && !isStore[1] && reqData[1].address_space_id == mtrac_pkg::ASI_STRAND
        && idx[1] == $past(idx[1]) && !wrStrand[1]) |=> rspData[1].rdata == $past(reqData[1].wdata, 2))
        else $error("strand readback wrong");
    a_core_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrCore[0] && !lost[0] && tgtCore[0] == 0 |=> coreRegs_reg[$past(idx[0])] == $past(reqData[0].wdata))
        else $error("core register not updated");

    c_proc_store: cover property (@(posedge clk_sys) disable iff (!rst_n) wrProc[0] && !lost[0]);
    c_collision:  cover property (@(posedge clk_sys) disable iff (!rst_n) |lost);
    c_run_drop:   cover property (@(posedge clk_sys) disable iff (!rst_n) |runDrop);
    c_priv_trap:  cover property (@(posedge clk_sys) disable iff (!rst_n)
        rspValid[0] && rspData[0].exc == mtrac_pkg::MTRAC_EXC_PRIV_ACTION);
endmodule

/* File: tb_top.sv */
// self-checking testbench of the multithread control register access controller
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned NS  = 4;
    localparam logic [63:0] PAT = 64'hdead_beef_0123_4567;
    logic                                  clk_sys;
    logic                                  rst_n;
    logic                  [63:0]          tickValue;
    logic                  [NS-1:0]        reqValid;
    mtrac_pkg::mtrac_req_t [NS-1:0]        reqData;
    logic                  [NS-1:0]        rspValid;
    mtrac_pkg::mtrac_rsp_t [NS-1:0]        rspData;
    int                                    err_total;
    int                                    comparisons;

    // 100 MHz clock
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    multithread_reg_access_ctrl #(.NUM_STRANDS(NS), .STRANDS_PER_CORE(2), .STRANDS_PER_SUB(2)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .reqData(reqData),
        .tickValue(tickValue), .rspValid(rspValid), .rspData(rspData));

    mtrac_lsu_model #(.NUM_STRANDS(NS)) lsu (
        .clk_sys(clk_sys), .rspValid(rspValid), .rspData(rspData), .reqValid(reqValid), .reqData(reqData));

    // ========================================
    // shared helpers
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    begin
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic acc(input int s, input mtrac_pkg::mtrac_op_t op, input mtrac_pkg::mtrac_mode_t mode,
                       input logic [7:0] address_space_id, input logic [15:0] va, input logic [63:0] wd, input logic grant);
    begin
        lsu.stage(s, op, mode, address_space_id, va, wd, grant);
        lsu.fire();
    end
    endtask

    task automatic ld(input int s, input logic [7:0] address_space_id, input logic [15:0] va);
    begin
        acc(s, mtrac_pkg::MTRAC_OP_LOAD_EXT, mtrac_pkg::MTRAC_HPRIV, address_space_id, va, 64'h0, 1'b0);
    end
    endtask

    task automatic st(input int s, input logic [7:0] address_space_id, input logic [15:0] va, input logic [63:0] wd);
    begin
        acc(s, mtrac_pkg::MTRAC_OP_STORE_EXT, mtrac_pkg::MTRAC_HPRIV, address_space_id, va, wd, 1'b0);
    end
    endtask

    // answer of one strand: valid, exception code and read data
    task automatic rsp(input int s, input mtrac_pkg::mtrac_exc_t e, input logic [63:0] d);
    begin
        chk("rspValid", 64'h1, 64'(lsu.seenValid[s]));
        chk("exc", 64'(e), 64'(lsu.seenData[s].exc));
        chk("rdata", d, lsu.seenData[s].rdata);
    end
    endtask

    // ========================================
    // scenarios
    task automatic t_walk();
    begin
        ld(0, 8'h66, 16'h0008);
        rsp(0, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        st(0, 8'h66, 16'h0008, PAT);
        rsp(0, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        ld(3, 8'h66, 16'h0008);
        rsp(3, mtrac_pkg::MTRAC_EXC_NONE, PAT);
    end
    endtask

    task automatic t_refuse();
    begin
        for (int m = 0; m < 2; m++)
        begin
            acc(0, mtrac_pkg::MTRAC_OP_STORE_EXT, mtrac_pkg::mtrac_mode_t'(m), 8'h66, 16'h0008, 64'h0, 1'b0);
            rsp(0, mtrac_pkg::MTRAC_EXC_PRIV_ACTION, 64'h0);
        end
        acc(1, mtrac_pkg::MTRAC_OP_OTHER, mtrac_pkg::MTRAC_HPRIV, 8'h66, 16'h0008, 64'h0, 1'b0);
        rsp(1, mtrac_pkg::MTRAC_EXC_DATA_ACCESS, 64'h0);
        ld(2, 8'h66, 16'h0008);
        rsp(2, mtrac_pkg::MTRAC_EXC_NONE, PAT);
        acc(0, mtrac_pkg::MTRAC_OP_STORE_DBL, mtrac_pkg::MTRAC_HPRIV, 8'h63, 16'h0000, 64'h1, 1'b0);
        rsp(0, mtrac_pkg::MTRAC_EXC_DATA_ACCESS, 64'h0);
        st(0, 8'h63, 16'h0000, 64'h1);
        rsp(0, mtrac_pkg::MTRAC_EXC_BAD_ASI, 64'h0);
        st(1, 8'h66, 16'h0038, 64'h1);
        rsp(1, mtrac_pkg::MTRAC_EXC_BAD_ASI, 64'h0);
        acc(2, mtrac_pkg::MTRAC_OP_STORE_DBL, mtrac_pkg::MTRAC_HPRIV, 8'h66, 16'h0010, 64'h77, 1'b0);
        rsp(2, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        acc(3, mtrac_pkg::MTRAC_OP_LOAD_DBL, mtrac_pkg::MTRAC_HPRIV, 8'h66, 16'h0010, 64'h0, 1'b0);
        rsp(3, mtrac_pkg::MTRAC_EXC_NONE, 64'h77);
        for (int v = 0; v < 3; v++)
        begin
            ld(0, (v == 2) ? 8'h70 : 8'h66, (v == 0) ? 16'h0004 : 16'h0040);
            rsp(0, mtrac_pkg::MTRAC_EXC_BAD_ASI, 64'h0);
        end
    end
    endtask

    task automatic t_sharing();
    begin
        for (int s = 0; s < NS; s++)
            lsu.stage(s, mtrac_pkg::MTRAC_OP_LOAD_EXT, mtrac_pkg::MTRAC_HPRIV, 8'h63, 16'h0000, 64'h0, 1'b0);
        lsu.fire();
        for (int s = 0; s < NS; s++)
            rsp(s, mtrac_pkg::MTRAC_EXC_NONE, 64'(s));
        st(0, 8'h63, 16'h0008, PAT);
        ld(1, 8'h63, 16'h0008);
        rsp(1, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        st(1, 8'h63, 16'h0008, 64'h42);
        ld(1, 8'h63, 16'h0008);
        rsp(1, mtrac_pkg::MTRAC_EXC_NONE, 64'h42);
        st(1, 8'h65, 16'h0008, 64'h55);
        ld(0, 8'h65, 16'h0008);
        rsp(0, mtrac_pkg::MTRAC_EXC_NONE, 64'h55);
        ld(2, 8'h65, 16'h0008);
        rsp(2, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        st(0, 8'h64, 16'h0010, 64'h99);
        ld(1, 8'h64, 16'h0010);
        rsp(1, mtrac_pkg::MTRAC_EXC_NONE, 64'h99);
        ld(3, 8'h64, 16'h0010);
        rsp(3, mtrac_pkg::MTRAC_EXC_NONE, 64'h0);
        for (int g = 0; g < 2; g++)
        begin
            acc(2, mtrac_pkg::MTRAC_OP_LOAD_EXT, mtrac_pkg::MTRAC_PRIV, 8'h67, 16'h0010, 64'h0, g[0]);
            rsp(2, (g == 0) ? mtrac_pkg::MTRAC_EXC_PRIV_ACTION : mtrac_pkg::MTRAC_EXC_NONE, 64'(g * 'h99));
        end
        ld(2, 8'h67, 16'h0090);
        rsp(2, mtrac_pkg::MTRAC_EXC_BAD_ASI, 64'h0);
    end
    endtask

    task automatic t_order();
    begin
        for (int k = 1; k < 3; k++)
        begin
            st(0, 8'h64, 16'h0018, 64'(k * 'h1010));
            ld(0, 8'h64, 16'h0018);
            rsp(0, mtrac_pkg::MTRAC_EXC_NONE, 64'(k * 'h1010));
        end
    end
    endtask

    task automatic t_collide();
    begin
        for (int s = 1; s < NS; s++)
            lsu.stage(s, mtrac_pkg::MTRAC_OP_STORE_EXT, mtrac_pkg::MTRAC_HPRIV, 8'h66, 16'h0018, 64'(s * 'h1111), 1'b0);
        lsu.fire();
        for (int s = 1; s < NS; s++)
            chk("overwritten", 64'(s > 1), 64'(lsu.seenData[s].overwritten));
        ld(0, 8'h66, 16'h0018);
        rsp(0, mtrac_pkg::MTRAC_EXC_NONE, 64'h1111);
        for (int s = 0; s < NS; s++)
            lsu.stage(s, mtrac_pkg::MTRAC_OP_STORE_EXT, mtrac_pkg::MTRAC_HPRIV, 8'h66, 16'h0000,
                      64'hffff_ffff_ffff_ffa0 + 64'(s), 1'b0);
        lsu.fire();
        for (int s = 0; s < NS; s++)
            chk("dropped", 64'(s > 0), 64'(lsu.seenData[s].dropped));
        ld(3, 8'h66, 16'h0000);
        rsp(3, mtrac_pkg::MTRAC_EXC_NONE, 64'h00a0);
        tickValue = PAT;
        ld(1, 8'h66, 16'h0038);
        rsp(1, mtrac_pkg::MTRAC_EXC_NONE, PAT);
    end
    endtask

    // ========================================
    // verdict, run sequence and watchdog
    task automatic report_and_stop();
    begin
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    initial
    begin
        err_total   = 0;
        comparisons = 0;
        rst_n       = 1'b0;
        tickValue   = 64'h0;
        repeat (5) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_walk();
        t_refuse();
        t_sharing();
        t_order();
        t_collide();
        lsu.fire();
        report_and_stop();
    end

    initial
    begin
        #20000;
        err_total++;
        report_and_stop();
    end
endmodule
